/* rtl/ofd_pkg.sv */
/*
 Package for the operand field decoder: field codes, register and segment
 enumerations, flag action codes, clock adjustment figures and carriers.
 Assumes a single core clock domain; no timing constants are needed.
*/
// Function
// - Direction bit swaps source and destination roles.
// - No size bit: full registers by mode.
// - Byte codes: low bytes below 100, high above.
// - 16-bit address classes pick displacement, frame uses stack.
// - 32-bit locator 100 means index byte follows.
// - Class 11 selects a register operand.
// - Index byte forms base plus scaled index.
// - Scale code gives factor one to eight.
// - Index code 100 means none, scale zero.
// - Legacy segment selector picks four segments.
// - Extended selector adds two segments, rest undefined.
// - Special register selector accepts listed codes only.
// - Each flag gets one of four actions.
// - Nine flags are tracked.
// - Two register address components add one clock.
// - Misaligned halfword or even word adds two/four.
// - Odd-address word adds four or eight clocks.
// - Base counts assume ideal conditions only.
// - Size bit zero picks bytes, one full size.
// - Over fifteen bytes raises a protection fault.
// - Size prefixes invert defaults for one instruction.
package ofd_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Field codes.
   localparam logic [1:0] OFD_CLASS_NODISP = 2'h0;   // No displacement class.
   localparam logic [1:0] OFD_CLASS_DISP8  = 2'h1;   // Byte displacement class.
   localparam logic [1:0] OFD_CLASS_DISPW  = 2'h2;   // Full displacement class.
   localparam logic [1:0] OFD_CLASS_REG    = 2'h3;   // Register operand class.
   localparam logic [2:0] OFD_LOC_SIB      = 3'h4;   // Index byte follows.
   localparam logic [2:0] OFD_LOC_DIR32    = 3'h5;   // Direct word displacement.
   localparam logic [2:0] OFD_LOC_DIR16    = 3'h6;   // Direct halfword displacement.
   localparam logic [2:0] OFD_IDX_NONE     = 3'h4;   // No index register.
   localparam logic [2:0] OFD_REG_SP       = 3'h4;   // Stack pointer code.
   localparam logic [2:0] OFD_REG_BP       = 3'h5;   // Frame pointer code.
   localparam logic [2:0] OFD_SEG_LAST_OK  = 3'h5;   // Highest defined segment code.
   localparam int         OFD_MAX_LEN      = 15;     // Longest legal instruction.
   localparam logic [7:0] OFD_PFX_OPSIZE   = 8'h66;  // Operand size prefix.
   localparam logic [7:0] OFD_PFX_ADSIZE   = 8'h67;  // Address size prefix.

   ////////////////////////////////////////////////////////////////////////
   // Clock adjustments.
   localparam logic [3:0] OFD_CLK_TWO_REG  = 4'h1;   // Two register components.
   localparam logic [3:0] OFD_CLK_MIS_RW   = 4'h2;   // Misaligned, read or write.
   localparam logic [3:0] OFD_CLK_MIS_RMW  = 4'h4;   // Misaligned, read and write.
   localparam logic [3:0] OFD_CLK_ODD_RW   = 4'h4;   // Odd word, read or write.
   localparam logic [3:0] OFD_CLK_ODD_RMW  = 4'h8;   // Odd word, read and write.

   ////////////////////////////////////////////////////////////////////////
   // Flag actions: update, keep, force zero, force one.
   localparam logic [1:0] OFD_FA_MOD  = 2'h0;        // Modified by result.
   localparam logic [1:0] OFD_FA_KEEP = 2'h1;        // Unchanged.
   localparam logic [1:0] OFD_FA_CLR  = 2'h2;        // Forced to zero.
   localparam logic [1:0] OFD_FA_SET  = 2'h3;        // Forced to one.
   localparam int         OFD_NFLAGS  = 9;           // Tracked flags.

   // Register operand: index, byte view, high byte, width code.
   typedef enum logic [1:0]
   {
      OFD_W8  = 2'h0,
      OFD_W16 = 2'h1,
      OFD_W32 = 2'h2
   } ofd_width_t;

   // Segment register selection.
   typedef enum logic [2:0]
   {
      OFD_SEG_EXTRA = 3'h0,
      OFD_SEG_CODE  = 3'h1,
      OFD_SEG_STACK = 3'h2,
      OFD_SEG_DATA  = 3'h3,
      OFD_SEG_AUXF  = 3'h4,
      OFD_SEG_AUXG  = 3'h5
   } ofd_seg_t;

   // Special register classes.
   typedef enum logic [1:0]
   {
      OFD_SPC_CTRL  = 2'h0,
      OFD_SPC_DEBUG = 2'h1,
      OFD_SPC_TEST  = 2'h2,
      OFD_SPC_NONE  = 2'h3
   } ofd_spc_t;

   // Register selection carrier.
   typedef struct packed
   {
      logic [2:0] num;       // General register number.
      logic       high_byte; // High byte of register num[1:0].
      ofd_width_t width;     // Access width.
   } ofd_reg_t;

   // Raw fields from the fetch queue.
   typedef struct packed
   {
      logic       has_w;     // Size select bit present.
      logic       w;         // Size select bit.
      logic       d;         // Direction bit.
      logic [1:0] cls;       // Addressing class.
      logic [2:0] reg_spec;  // Register specifier.
      logic [2:0] loc;       // Operand locator.
      logic [1:0] scale;     // Scale code.
      logic [2:0] idx;       // Index code.
      logic [2:0] base;      // Base code.
      logic       seg_ext;   // Extended segment selector in use.
      logic [2:0] seg_sel;   // Segment selector code.
      logic       spc_use;   // Special register selector in use.
      ofd_spc_t   spc_cls;   // Special register class.
      logic [2:0] spc_sel;   // Special register code.
      logic [17:0] flag_act; // Two bits per flag, overflow first.
      logic       mem_rd;    // Memory read.
      logic       mem_wr;    // Memory write.
      logic [1:0] addr_lo;   // Operand address low bits.
      logic [3:0] length;    // Total byte count, 0 means sixteen or more.
      logic [7:0] prefix_a;  // First prefix byte, 0 if none.
      logic [7:0] prefix_b;  // Second prefix byte, 0 if none.
   } ofd_fields_t;

   // Decoded result for address generation.
   typedef struct packed
   {
      ofd_reg_t   src;       // Source register.
      ofd_reg_t   dst;       // Destination register.
      logic       src_is_mem;// Source is the memory operand.
      logic       dst_is_mem;// Destination is the memory operand.
      logic       use_base;  // Base register used.
      logic [2:0] base;      // Base register number.
      logic       use_index; // Index register used.
      logic [2:0] index;     // Index register number.
      logic [3:0] scale_f;   // Index multiplier.
      logic [1:0] disp_len;  // Displacement bytes code: 0,1,2,4 as 0..3.
      ofd_seg_t   seg;       // Segment in use, override or default.
      logic       addr32;    // 32-bit addressing in force.
      logic       op32;      // 32-bit operands in force.
      logic [3:0] clk_adj;   // Extra clocks.
   } ofd_dec_t;

endpackage

/* rtl/ofd_regsel.sv */
/*
 General register selector: maps a three-bit code, the size select bit and
 the operand size onto a register number, byte view and width.
 Assumes purely combinational use inside the decoder.
*/
`timescale 1ns/100ps
`default_nettype none
module ofd_regsel
   import ofd_pkg::*;
(
   input  wire logic       i_code,
   input  wire logic [2:0] i_num,
   input  wire logic       i_has_w,
   input  wire logic       i_w,
   input  wire logic       i_op32,
   output var ofd_reg_t    o_sel
);
   // Byte access when the size bit is present and clear.
   wire byte_mode = i_has_w & ~i_w;

   assign o_sel.num       = byte_mode ? {1'b0, i_num[1:0]} : i_num;
   assign o_sel.high_byte = byte_mode & i_num[2];
   assign o_sel.width     = byte_mode ? OFD_W8 : (i_op32 ? OFD_W32 : OFD_W16);
   wire unused_code = i_code;
endmodule
`default_nettype wire

/* rtl/ofd_top.sv */
/*
 Operand field decoder top: registers one decoded instruction per clock from
 the fetch queue fields into the address generation stage.
 Assumes the fetch queue presents complete, already split fields with a
 valid strobe in the core clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module ofd_top
   import ofd_pkg::*;
(
   input  wire logic        I_CLK_SYS,
   input  wire logic        I_RESETN,
   input  wire logic        I_VALID,
   input  wire ofd_fields_t I_FIELDS,
   input  wire logic        I_DEF_OP32,
   input  wire logic        I_DEF_AD32,
   output logic             O_VALID,
   output var ofd_dec_t     O_DEC,
   output logic [17:0]      O_FLAG_ACT,
   output logic             O_INVALID,
   output logic             O_GP_FAULT,
   output logic [15:0]      O_GP_CODE,
   output logic             O_UNDEF_EA
);
   ////////////////////////////////////////////////////////////////////////
   // Prefix handling.

   wire op_pfx = (I_FIELDS.prefix_a == OFD_PFX_OPSIZE) |
                 (I_FIELDS.prefix_b == OFD_PFX_OPSIZE);
   wire ad_pfx = (I_FIELDS.prefix_a == OFD_PFX_ADSIZE) |
                 (I_FIELDS.prefix_b == OFD_PFX_ADSIZE);
   wire op32   = I_DEF_OP32 ^ op_pfx;
   wire ad32   = I_DEF_AD32 ^ ad_pfx;

   ////////////////////////////////////////////////////////////////////////
   // Register selections.
   ofd_reg_t reg_sel;   // Register specifier result.
   ofd_reg_t loc_sel;   // Register operand from the locator.

   ofd_regsel u_reg
   (
      .i_code  (1'b0),
      .i_num   (I_FIELDS.reg_spec),
      .i_has_w (I_FIELDS.has_w),
      .i_w     (I_FIELDS.w),
      .i_op32  (op32),
      .o_sel   (reg_sel)
   );
   ofd_regsel u_loc
   (
      .i_code  (1'b1),
      .i_num   (I_FIELDS.loc),
      .i_has_w (I_FIELDS.has_w),
      .i_w     (I_FIELDS.w),
      .i_op32  (op32),
      .o_sel   (loc_sel)
   );

   wire is_reg = (I_FIELDS.cls == OFD_CLASS_REG);

   wire d = I_FIELDS.d;
   wire src_mem = d & ~is_reg;
   wire dst_mem = ~d & ~is_reg;
   ofd_reg_t src_r;
   ofd_reg_t dst_r;
   assign src_r = d ? loc_sel : reg_sel;
   assign dst_r = d ? reg_sel : loc_sel;

   ////////////////////////////////////////////////////////////////////////
   // 16-bit address forms.
   logic       b16_use;
   logic [2:0] b16_base;
   logic       i16_use;
   logic [2:0] i16_idx;
   logic       s16_stack;
   logic [1:0] d16_len;

   // Combinational decode of the 16-bit locator table.
   // Halfword address forms
   always_comb
   begin
      b16_use   = 1'b1;
      b16_base  = 3'h3;
      i16_use   = 1'b0;
      i16_idx   = 3'h6;
      s16_stack = 1'b0;
      case (I_FIELDS.loc)
         3'h0: i16_use = 1'b1;
         3'h1:
         begin
            i16_use = 1'b1;
            i16_idx = 3'h7;
         end
         3'h2:
         begin
            b16_base  = OFD_REG_BP;
            i16_use   = 1'b1;
            s16_stack = 1'b1;
         end
         3'h3:
         begin
            b16_base  = OFD_REG_BP;
            i16_use   = 1'b1;
            i16_idx   = 3'h7;
            s16_stack = 1'b1;
         end
         3'h4: b16_base = 3'h6;
         3'h5: b16_base = 3'h7;
         3'h6:
         begin
            // Frame pointer alone, or direct address in class zero.
            b16_base  = OFD_REG_BP;
            s16_stack = (I_FIELDS.cls != OFD_CLASS_NODISP);
            b16_use   = (I_FIELDS.cls != OFD_CLASS_NODISP);
         end
         default: b16_base = 3'h3;
      endcase
      case (I_FIELDS.cls)
         OFD_CLASS_DISP8: d16_len = 2'h1;
         OFD_CLASS_DISPW: d16_len = 2'h2;
         default:
            d16_len = (I_FIELDS.loc == OFD_LOC_DIR16) ? 2'h2 : 2'h0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // 32-bit address forms.

   wire sib     = ~is_reg & (I_FIELDS.loc == OFD_LOC_SIB);
   wire dir32   = (I_FIELDS.cls == OFD_CLASS_NODISP) &
                  (I_FIELDS.loc == OFD_LOC_DIR32);
   wire [2:0] b32 = sib ? I_FIELDS.base : I_FIELDS.loc;
   wire b32_use = ~dir32;
   wire i32_use = sib & (I_FIELDS.idx != OFD_IDX_NONE);
   wire undef_ea = sib & ~i32_use & (I_FIELDS.scale != 2'h0);
   wire s32_stack = (b32 == OFD_REG_SP & sib) |
                    (b32 == OFD_REG_BP & I_FIELDS.cls != OFD_CLASS_NODISP);
   logic [1:0] d32_len;
   always_comb
   begin
      case (I_FIELDS.cls)
         OFD_CLASS_DISP8: d32_len = 2'h1;
         OFD_CLASS_DISPW: d32_len = 2'h3;
         default:         d32_len = dir32 ? 2'h3 : 2'h0;
      endcase
   end

   wire [3:0] scale_f = 4'h1 << I_FIELDS.scale;

   ////////////////////////////////////////////////////////////////////////
   // Segments and special registers.

   wire [2:0] seg_code = I_FIELDS.seg_ext ? I_FIELDS.seg_sel
                                          : {1'b0, I_FIELDS.seg_sel[1:0]};
   wire seg_bad = I_FIELDS.seg_ext & (seg_code > OFD_SEG_LAST_OK);
   logic spc_ok;
   always_comb
   begin
      case (I_FIELDS.spc_cls)
         OFD_SPC_CTRL:  spc_ok = (I_FIELDS.spc_sel == 3'h0) |
                                 (I_FIELDS.spc_sel == 3'h2) |
                                 (I_FIELDS.spc_sel == 3'h3);
         OFD_SPC_DEBUG: spc_ok = (I_FIELDS.spc_sel[2:1] != 2'h2);
         OFD_SPC_TEST:  spc_ok = (I_FIELDS.spc_sel >= 3'h3);
         default:       spc_ok = 1'b0;
      endcase
   end
   wire invalid = seg_bad | (I_FIELDS.spc_use & ~spc_ok);

   ////////////////////////////////////////////////////////////////////////
   // Clock adjustments.

   wire two_reg = ~is_reg & (ad32 ? (b32_use & i32_use) : (b16_use & i16_use));
   wire rmw     = I_FIELDS.mem_rd & I_FIELDS.mem_wr;
   wire acc     = (I_FIELDS.mem_rd | I_FIELDS.mem_wr) & ~is_reg;
   wire word    = ~(I_FIELDS.has_w & ~I_FIELDS.w) & op32;
   wire half    = ~(I_FIELDS.has_w & ~I_FIELDS.w) & ~op32;
   logic [3:0] mis_adj;
   // Alignment penalties; base counts assume no waits or exceptions.
   // Alignment clocks
   always_comb
   begin
      mis_adj = 4'h0;
      if (acc & word & I_FIELDS.addr_lo[0])
         mis_adj = rmw ? OFD_CLK_ODD_RMW : OFD_CLK_ODD_RW;
      else if (acc & ((word & I_FIELDS.addr_lo[1]) | (half & I_FIELDS.addr_lo[0])))
         mis_adj = rmw ? OFD_CLK_MIS_RMW : OFD_CLK_MIS_RW;
   end
   wire [3:0] clk_adj = mis_adj + (two_reg ? OFD_CLK_TWO_REG : 4'h0);

   ////////////////////////////////////////////////////////////////////////
   // Length check.

   wire too_long = (I_FIELDS.length == 4'h0);

   ////////////////////////////////////////////////////////////////////////
   // Assemble the decoded word.
   ofd_dec_t dec_next;
   always_comb
   begin
      dec_next            = '0;
      dec_next.src        = src_r;
      dec_next.dst        = dst_r;
      dec_next.src_is_mem = src_mem;
      dec_next.dst_is_mem = dst_mem;
      dec_next.use_base   = ~is_reg & (ad32 ? b32_use : b16_use);
      dec_next.base       = ad32 ? b32 : b16_base;
      dec_next.use_index  = ~is_reg & (ad32 ? i32_use : i16_use);
      dec_next.index      = ad32 ? I_FIELDS.idx : i16_idx;
      dec_next.scale_f    = (ad32 & sib) ? scale_f : 4'h1;
      dec_next.disp_len   = is_reg ? 2'h0 : (ad32 ? d32_len : d16_len);
      dec_next.addr32     = ad32;
      dec_next.op32       = op32;
      dec_next.clk_adj    = clk_adj;
      if (I_FIELDS.seg_sel != 3'h0 | I_FIELDS.seg_ext)
         dec_next.seg = ofd_seg_t'(seg_code);
      else
         dec_next.seg = ((ad32 ? s32_stack : s16_stack) & ~is_reg) ? OFD_SEG_STACK
                                                                   : OFD_SEG_DATA;
   end

   ////////////////////////////////////////////////////////////////////////
   // Output stage, one instruction per clock.
   // Registered outputs
   always_ff @(posedge I_CLK_SYS)
   begin
      if (!I_RESETN)
      begin
         O_VALID    <= 1'b0;
         O_DEC      <= '0;
         O_FLAG_ACT <= '0;
         O_INVALID  <= 1'b0;
         O_GP_FAULT <= 1'b0;
         O_GP_CODE  <= 16'h0000;
         O_UNDEF_EA <= 1'b0;
      end
      else
      begin
         O_VALID <= I_VALID;
         if (I_VALID)
         begin
            O_DEC      <= dec_next;
            O_FLAG_ACT <= I_FIELDS.flag_act;
            O_INVALID  <= invalid;
            O_GP_FAULT <= too_long;
            O_GP_CODE  <= 16'h0000;
            O_UNDEF_EA <= undef_ea & ad32;
         end
      end
   end
endmodule
`default_nettype wire

/* tb/ofd_checker.sv */
/*
 Concurrent checks on the operand field decoder top ports.
 Assumes one core clock and a synchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module ofd_checker
   import ofd_pkg::*;
(
   input  wire logic        I_CLK_SYS,
   input  wire logic        I_RESETN,
   input  wire logic        I_VALID,
   input  wire ofd_fields_t I_FIELDS,
   input  wire logic        I_DEF_OP32,
   input  wire logic        I_DEF_AD32,
   input  wire logic        O_VALID,
   input  wire ofd_dec_t    O_DEC,
   input  wire logic [17:0] O_FLAG_ACT,
   input  wire logic        O_INVALID,
   input  wire logic        O_GP_FAULT,
   input  wire logic [15:0] O_GP_CODE,
   input  wire logic        O_UNDEF_EA
);
   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (!I_RESETN);
   ////////////////////////////////////////////////////////////
   // Sizes in force after the prefixes, and the index byte case.
   wire logic [7:0] pa  = I_FIELDS.prefix_a;
   wire logic [7:0] pb  = I_FIELDS.prefix_b;
   wire logic       op  = I_DEF_OP32 ^ (pa == OFD_PFX_OPSIZE || pb == OFD_PFX_OPSIZE);
   wire logic       ad  = I_DEF_AD32 ^ (pa == OFD_PFX_ADSIZE || pb == OFD_PFX_ADSIZE);
   wire logic       sib = I_VALID && ad && I_FIELDS.cls != OFD_CLASS_REG
                          && I_FIELDS.loc == OFD_LOC_SIB;
   wire logic       nix = I_FIELDS.idx == OFD_IDX_NONE;
   ////////////////////////////////////////////////////////////
   a_valid_next: assert property (I_VALID |=> O_VALID)
      else $error("accepted fields gave no valid pulse");
   a_idle_hold: assert property (!I_VALID |=> !O_VALID && $stable(O_DEC))
      else $error("idle cycle changed the outputs");
   a_dir_roles: assert property (I_VALID && I_FIELDS.cls != OFD_CLASS_REG |=>
      O_DEC.dst_is_mem == !$past(I_FIELDS.d) && O_DEC.src_is_mem == $past(I_FIELDS.d))
      else $error("memory operand on the wrong side");
   a_reg_class: assert property (I_VALID && I_FIELDS.cls == OFD_CLASS_REG |=>
      !O_DEC.src_is_mem && !O_DEC.dst_is_mem) else $error("register class used memory");
   a_flag_copy: assert property (I_VALID |=> O_FLAG_ACT == $past(I_FIELDS.flag_act))
      else $error("flag actions not carried");
   a_gp_length: assert property (I_VALID |=> O_GP_CODE == 16'h0 &&
      O_GP_FAULT == ($past(I_FIELDS.length) == 4'h0)) else $error("length fault wrong");
   a_seg_undef: assert property (I_VALID && I_FIELDS.seg_ext &&
      I_FIELDS.seg_sel > OFD_SEG_LAST_OK |=> O_INVALID) else $error("bad segment passed");
   a_scale_fac: assert property (sib && !nix |=> O_DEC.use_index &&
      O_DEC.scale_f == 4'h1 << $past(I_FIELDS.scale)) else $error("scale factor wrong");
   a_idx_none: assert property (sib && nix |=> !O_DEC.use_index &&
      O_UNDEF_EA == ($past(I_FIELDS.scale) != 2'h0)) else $error("no-index case wrong");
   a_size_pfx: assert property (I_VALID |=> O_DEC.op32 == $past(op) &&
      O_DEC.addr32 == $past(ad)) else $error("size prefix not applied");
endmodule
`default_nettype wire

/* tb/ofd_fetch_model.sv */
/*
 Fetch queue model: hands one whole field set per push to the decoder.
 Assumes the bench sets its request shortly after a rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module ofd_fetch_model
   import ofd_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_push,
   input  wire logic        i_bad,
   input  wire ofd_fields_t i_fld,
   output logic             o_valid = 1'b0,
   output var ofd_fields_t  o_fld = '0
);
   ofd_fields_t f;   // Field set after the model's own fix-up.
   // Launch one registered field set; idle lines toggle every cycle.
   // whole set per cycle
   always @(posedge i_clk)
   begin
      f = i_fld;
      if (!i_bad && f.idx == OFD_IDX_NONE)
         f.scale = 2'h0;
      o_valid <= #1 i_push;
      o_fld   <= #1 i_push ? f : ~o_fld;
   end
endmodule
`default_nettype wire

/* tb/tb.sv */
/*
 Self-checking bench for the operand field decoder.
 Assumes the fetch model and the checker files are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb
   import ofd_pkg::*;
;
   logic        clk = 1'b0;   // Core clock, 4 ns period.
   logic        rstn = 1'b0;  // Synchronous reset, active low.
   logic        push = 1'b0;  // Request to the fetch model.
   logic        bad = 1'b0;   // Lets a scale slip through without index.
   logic        op32 = 1'b0;  // Default operand size.
   logic        ad32 = 1'b0;  // Default address size.
   ofd_fields_t fld = '0;     // Fields handed to the model.
   logic        v_i;
   ofd_fields_t f_i;
   logic        o_valid, o_invalid, o_gp_fault, o_undef_ea;
   ofd_dec_t    o_dec;
   logic [17:0] o_flag_act;
   logic [15:0] o_gp_code;
   int          num_errors = 0;
   int          checks = 0;
   always #2 clk = ~clk;
   ofd_fetch_model u_fetch (.i_clk(clk), .i_push(push), .i_bad(bad), .i_fld(fld),
                            .o_valid(v_i), .o_fld(f_i));
   ofd_top dut (.I_CLK_SYS(clk), .I_RESETN(rstn), .I_VALID(v_i), .I_FIELDS(f_i),
                .I_DEF_OP32(op32), .I_DEF_AD32(ad32), .O_VALID(o_valid), .O_DEC(o_dec),
                .O_FLAG_ACT(o_flag_act), .O_INVALID(o_invalid), .O_GP_FAULT(o_gp_fault),
                .O_GP_CODE(o_gp_code), .O_UNDEF_EA(o_undef_ea));
   ////////////////////////////////////////////////////////////
   // Shared helpers.
   task automatic results();
      if (num_errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask
   function automatic ofd_fields_t fb(input logic [1:0] c, input logic [2:0] l);
      fb = '0;
      fb.cls = c;
      fb.loc = l;
      fb.length = 4'h3;
      fb.spc_cls = OFD_SPC_NONE;
   endfunction
   // One transfer: push, then wait a bounded time for the valid pulse.
   task automatic xfer(input ofd_fields_t f, input logic b);
      int n;
      @(posedge clk);
      #1 push = 1'b1;
      fld = f;
      bad = b;
      @(posedge clk);
      #1 push = 1'b0;
      n = 0;
      while (o_valid !== 1'b1 && n < 5)
      begin
         @(posedge clk);
         #1 n++;
      end
      chk("valid", 1, o_valid);
   endtask
   task automatic chk_reg(input ofd_reg_t r, input logic [2:0] c, input logic y,
                          input ofd_width_t w);
      chk("num", y ? {1'b0, c[1:0]} : c, r.num);
      chk("high", y & c[2], r.high_byte);
      chk("width", w, r.width);
   endtask
   ////////////////////////////////////////////////////////////
   // Register operands for every code, size bit form and operand size.
   task automatic t_regs();
      ofd_fields_t f;
      logic        y;
      ofd_width_t  w;
      for (int i = 0; i < 64; i++)
      begin
         f = fb(OFD_CLASS_REG, ~i[2:0]);
         f.reg_spec = i[2:0];
         f.has_w = i[3];
         f.w = i[4];
         f.d = i[0] ^ i[1];
         op32 = i[5];
         xfer(f, 1'b0);
         y = i[3] & ~i[4];
         w = y ? OFD_W8 : (i[5] ? OFD_W32 : OFD_W16);
         chk_reg(f.d ? o_dec.dst : o_dec.src, i[2:0], y, w);
         chk_reg(f.d ? o_dec.src : o_dec.dst, ~i[2:0], y, w);
      end
   endtask
   // Memory forms: displacement length, segment and clock adjustment.
   task automatic am(input logic a, input logic [1:0] c, input logic [2:0] l, b, x,
                     input logic [1:0] ed, input ofd_seg_t es, input logic [3:0] ek,
                     input logic [7:0] ea);
      ofd_fields_t f;
      f = fb(c, l);
      f.base = b;
      f.idx = x;
      f.d = l[0];
      ad32 = a;
      xfer(f, 1'b0);
      chk("disp", ed, o_dec.disp_len);
      chk("seg", es, o_dec.seg);
      chk("clk", ek, o_dec.clk_adj);
      chk("ea", ea, {o_dec.use_base, o_dec.use_base ? o_dec.base : 3'h0,
                     o_dec.use_index, o_dec.use_index ? o_dec.index : 3'h0});
   endtask
   task automatic t_addr();
      op32 = 1'b0;
      am(0, 0, 6, 0, 0, 2, OFD_SEG_DATA, 0, 8'h00);
      am(0, 0, 0, 0, 0, 0, OFD_SEG_DATA, 1, 8'hbe);
      am(0, 1, 2, 0, 0, 1, OFD_SEG_STACK, 1, 8'hde);
      am(0, 2, 6, 0, 0, 2, OFD_SEG_STACK, 0, 8'hd0);
      am(1, 0, 5, 0, 0, 3, OFD_SEG_DATA, 0, 8'h00);
      am(1, 1, 5, 0, 0, 1, OFD_SEG_STACK, 0, 8'hd0);
      am(1, 2, 0, 0, 0, 3, OFD_SEG_DATA, 0, 8'h80);
      am(1, 0, 4, 4, 1, 0, OFD_SEG_STACK, 1, 8'hc9);
      am(1, 1, 4, 5, 4, 1, OFD_SEG_STACK, 0, 8'hd0);
      am(1, 2, 4, 0, 2, 3, OFD_SEG_DATA, 1, 8'h8a);
   endtask
   // Scale codes, then a missing index with and without a stray scale.
   task automatic t_scale();
      ofd_fields_t f;
      ad32 = 1'b1;
      for (int s = 0; s < 6; s++)
      begin
         f = fb(OFD_CLASS_NODISP, OFD_LOC_SIB);
         f.idx = s < 4 ? 3'h1 : OFD_IDX_NONE;
         f.scale = s < 4 ? s[1:0] : 2'h1;
         xfer(f, s == 4);
         if (s < 4)
            chk("scale", 4'h1 << s, o_dec.scale_f);
         chk("undef", s == 4, o_undef_ea);
      end
   endtask
   // Segment selectors, both forms, with the undefined codes.
   task automatic t_seg();
      ofd_fields_t f;
      ad32 = 1'b0;
      for (int i = 0; i < 11; i++)
      begin
         f = fb(OFD_CLASS_NODISP, 3'h4);
         f.seg_ext = i < 8;
         f.seg_sel = i < 8 ? i[2:0] : 3'(i - 7);
         xfer(f, 1'b0);
         chk("seg", f.seg_sel, o_dec.seg);
         chk("inv", f.seg_ext && f.seg_sel > 3'h5, o_invalid);
      end
   endtask
   // Special register selector: control, debug and test classes against every code.
   task automatic t_spc();
      ofd_fields_t f;
      logic [7:0]  mk [3] = '{8'h0d, 8'hcf, 8'hf8};
      for (int i = 0; i < 24; i++)
      begin
         f = fb(OFD_CLASS_REG, 3'h0);
         f.spc_use = 1'b1;
         f.spc_cls = ofd_spc_t'(i / 8);
         f.spc_sel = i[2:0];
         xfer(f, 1'b0);
         chk("spc", !mk[i / 8][i % 8], o_invalid);
      end
   endtask
   // Operand alignment penalties on a single-register address.
   task automatic mis(input logic o, input logic [1:0] lo, input logic r, w,
                      input logic [3:0] k);
      ofd_fields_t f;
      f = fb(OFD_CLASS_NODISP, 3'h0);
      f.addr_lo = lo;
      f.mem_rd = r;
      f.mem_wr = w;
      op32 = o;
      ad32 = 1'b1;
      xfer(f, 1'b0);
      chk("clk", k, o_dec.clk_adj);
   endtask
   // Length limit and flag action carriage.
   task automatic t_misc();
      ofd_fields_t f;
      logic [3:0]  ln [3] = '{4'hf, 4'h0, 4'h1};
      for (int k = 0; k < 3; k++)
      begin
         f = fb(OFD_CLASS_REG, 3'h1);
         f.length = ln[k];
         f.flag_act = {ln[k], 14'h1a5c};
         xfer(f, 1'b0);
         chk("gp", ln[k] == 4'h0, o_gp_fault);
         chk("gpcode", 0, o_gp_code);
         chk("flags", f.flag_act, o_flag_act);
      end
   endtask
   // Two prefixed instructions back to back; each prefix acts once.
   task automatic t_pfx();
      ofd_fields_t a, b;
      a = fb(OFD_CLASS_REG, 3'h0);
      b = a;
      a.prefix_a = OFD_PFX_OPSIZE;
      b.prefix_b = OFD_PFX_ADSIZE;
      op32 = 1'b0;
      ad32 = 1'b0;
      @(posedge clk);
      #1 push = 1'b1;
      fld = a;
      @(posedge clk);
      #1 fld = b;
      @(posedge clk);
      #1 push = 1'b0;
      chk("pfx1", 3'b110, {o_valid, o_dec.op32, o_dec.addr32});
      @(posedge clk);
      #1 chk("pfx2", 3'b101, {o_valid, o_dec.op32, o_dec.addr32});
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20) @(posedge clk);
      #1 rstn = 1'b1;
      chk("rst", 0, {o_valid, o_invalid, o_gp_fault, o_undef_ea});
      t_regs();
      t_addr();
      t_scale();
      t_seg();
      t_spc();
      mis(1, 1, 1, 0, 4);
      mis(1, 1, 1, 1, 8);
      mis(1, 2, 0, 1, 2);
      mis(1, 2, 1, 1, 4);
      mis(0, 1, 1, 0, 2);
      mis(0, 3, 1, 1, 4);
      mis(0, 2, 1, 1, 0);
      t_misc();
      t_pfx();
      results();
   end
   // Watchdog far beyond the four hundred or so cycles the tests need.
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      results();
   end
endmodule
bind ofd_top ofd_checker u_chk (.I_CLK_SYS(I_CLK_SYS), .I_RESETN(I_RESETN),
   .I_VALID(I_VALID), .I_FIELDS(I_FIELDS), .I_DEF_OP32(I_DEF_OP32),
   .I_DEF_AD32(I_DEF_AD32), .O_VALID(O_VALID), .O_DEC(O_DEC), .O_FLAG_ACT(O_FLAG_ACT),
   .O_INVALID(O_INVALID), .O_GP_FAULT(O_GP_FAULT), .O_GP_CODE(O_GP_CODE),
   .O_UNDEF_EA(O_UNDEF_EA));
`default_nettype wire
